// [shared/dtim_defs.svh]
// Constants for the dual timer and external interrupt control block.
// Assumes inclusion by bare name from the design files.
`ifndef DTIM_DEFS_SVH
`define DTIM_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DTIM_IDX_CTRL   10'h088
`define DTIM_IDX_MODE   10'h089
`define DTIM_IDX_TL0    10'h08a
`define DTIM_IDX_TL1    10'h08b
`define DTIM_IDX_TH0    10'h08c
`define DTIM_IDX_TH1    10'h08d
`define DTIM_IDX_CLK    10'h08e
`define DTIM_IDX_ISTAT  10'h090
`define DTIM_IDX_IMASK  10'h091

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DTIM_B_TF1      7
`define DTIM_B_TR1      6
`define DTIM_B_TF0      5
`define DTIM_B_TR0      4
`define DTIM_B_IE1      3
`define DTIM_B_IT1      2
`define DTIM_B_IE0      1
`define DTIM_B_IT0      0
`define DTIM_B_CK1      4
`define DTIM_B_CK0      3

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define DTIM_RST_BYTE   8'h00
`define DTIM_DIV_SLOW   4'hc
`define DTIM_DIV_FAST   2'h3

`endif

// [shared/dtim_pkg.sv]
// Types for the dual timer and external interrupt control block.
// Assumes nothing beyond a SystemVerilog compiler.
package dtim_pkg;

    // Mode field codes
    typedef enum logic [1:0] {
        DTIM_M13    = 2'b00,
        DTIM_M16    = 2'b01,
        DTIM_RELOAD = 2'b10,
        DTIM_SPLIT  = 2'b11
    } dtim_mode_e_t;

    // One timer nibble of the mode register
    typedef struct packed {
        logic         gate;
        logic         ctr;
        dtim_mode_e_t mode;
    } dtim_mode_t;

    // Result of one count step
    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic       ovf;
    } dtim_step_t;

endpackage : dtim_pkg

// [rtl/dtim_top.sv]
// Dual timer/counter with external interrupt detect and APB registers.
// Assumes an APB master on core_clk (reads add no wait state), async pins.
`timescale 1ns/1ps
`include "dtim_defs.svh"

module dtim_top (
    // Clock, reset, freeze
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // External pins
    input  wire logic        ext_irq0_pin,
    input  wire logic        ext_irq1_pin,
    input  wire logic        count_pin_0,
    input  wire logic        count_pin_1,
    // Vector acknowledges from the CPU
    input  wire logic        vec_t0,
    input  wire logic        vec_t1,
    input  wire logic        vec_x0,
    input  wire logic        vec_x1,
    // Flags and interrupt
    output logic             t0_overflow_flag,
    output logic             t1_overflow_flag,
    output logic             ext_irq0_detect_flag,
    output logic             ext_irq1_detect_flag,
    output logic             irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Mapped register test
    function automatic logic dtim_hit(input logic [11:0] a);
        logic [9:0] i;
        i = a[11:2];
        return (a[1:0] == 2'h0) &&
               (i == `DTIM_IDX_CTRL  || i == `DTIM_IDX_MODE  ||
                i == `DTIM_IDX_TL0   || i == `DTIM_IDX_TL1   ||
                i == `DTIM_IDX_TH0   || i == `DTIM_IDX_TH1   ||
                i == `DTIM_IDX_CLK   || i == `DTIM_IDX_ISTAT ||
                i == `DTIM_IDX_IMASK);
    endfunction : dtim_hit

    // One count step in the given mode
    function automatic dtim_pkg::dtim_step_t dtim_step(
        input dtim_pkg::dtim_mode_e_t mode,
        input logic [7:0]             tl,
        input logic [7:0]             th);
        dtim_pkg::dtim_step_t s;
        s.tl  = tl;
        s.th  = th;
        s.ovf = 1'b0;
        unique case (mode)
            dtim_pkg::DTIM_M13: begin
                if (tl[4:0] == 5'h1f) begin
                    s.tl  = {tl[7:5], 5'h00};
                    s.th  = th + 8'h01;
                    s.ovf = (th == 8'hff);
                end else begin
                    s.tl = tl + 8'h01;
                end
            end
            dtim_pkg::DTIM_M16: begin
                {s.th, s.tl} = {th, tl} + 16'h0001;
                s.ovf        = &{th, tl};
            end
            dtim_pkg::DTIM_RELOAD: begin
                s.tl  = (tl == 8'hff) ? th : tl + 8'h01;
                s.ovf = (tl == 8'hff);
            end
            dtim_pkg::DTIM_SPLIT: begin
                s.tl  = tl + 8'h01;
                s.ovf = (tl == 8'hff);
            end
        endcase
        return s;
    endfunction : dtim_step

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [3:0] pin_meta, pin_sync;   // {cnt1, cnt0, irq1, irq0}
    logic [1:0] cnt_prev, irq_samp;
    logic [3:0] div12;
    logic [1:0] div4;
    logic [7:0] ctrl, mode_cfg, tl0, th0, tl1, th1;
    logic [1:0] clk_sel;              // {timer1, timer0}
    logic [3:0] istat, imask;
    logic       data_ok;

    logic [1:0] next_cnt_prev, next_irq_samp, next_div4;
    logic [3:0] next_div12;
    logic [7:0] next_ctrl, next_mode_cfg, next_tl0, next_th0;
    logic [7:0] next_tl1, next_th1;
    logic [1:0] next_clk_sel;
    logic [3:0] next_istat, next_imask;
    logic       next_data_ok;
    logic [31:0] next_prdata;

    logic tick12, tick4, src0, src1, en0, en0h, en1, split;
    logic ovf0, ovf0h, ovf1, tf1_set;
    logic [1:0] cnt_fall, irq_fall;
    logic wr, wr_ctrl;
    dtim_pkg::dtim_mode_t m0, m1;
    dtim_pkg::dtim_step_t st0, st1;

    // ------------------------------------------------------------
    // Prescaler and pin sampling
    // ------------------------------------------------------------
    // Machine-cycle and fast tick dividers, pin edge detection
    always_comb begin
        tick12        = ce & (div12 == `DTIM_DIV_SLOW - 4'h1);
        tick4         = ce & (div4 == `DTIM_DIV_FAST);
        next_div12    = tick12 ? 4'h0 : div12 + 4'h1;
        next_div4     = div4 + 2'h1;
        cnt_fall      = cnt_prev & ~pin_sync[3:2];
        next_cnt_prev = pin_sync[3:2];
        irq_fall      = {2{tick12}} & irq_samp & ~pin_sync[1:0];
        next_irq_samp = tick12 ? pin_sync[1:0] : irq_samp;
    end

    // Two-stage synchroniser and divider registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 4'hf;
            pin_sync <= 4'hf;
            cnt_prev <= 2'h3;
            irq_samp <= 2'h3;
            div12    <= 4'h0;
            div4     <= 2'h0;
        end else if (ce) begin
            pin_meta <= {count_pin_1, count_pin_0,
                         ext_irq1_pin, ext_irq0_pin};
            pin_sync <= pin_meta;
            cnt_prev <= next_cnt_prev;
            irq_samp <= next_irq_samp;
            div12    <= next_div12;
            div4     <= next_div4;
        end
    end

    // ------------------------------------------------------------
    // Timers and control flags
    // ------------------------------------------------------------
    assign wr      = psel & penable & pwrite & ce & dtim_hit(paddr);
    assign wr_ctrl = wr & (paddr[11:2] == `DTIM_IDX_CTRL);

    // Count enables, steps, overflows and flag updates
    always_comb begin
        m0    = dtim_pkg::dtim_mode_t'(mode_cfg[3:0]);
        m1    = dtim_pkg::dtim_mode_t'(mode_cfg[7:4]);
        split = (m0.mode == dtim_pkg::DTIM_SPLIT);
        src0  = m0.ctr ? cnt_fall[0]
                       : (clk_sel[0] ? tick4 : tick12);
        src1  = m1.ctr ? cnt_fall[1]
                       : (clk_sel[1] ? tick4 : tick12);
        en0   = ctrl[`DTIM_B_TR0] & src0 &
                (~m0.gate | pin_sync[0]);
        en1   = ctrl[`DTIM_B_TR1] & src1 &
                (~m1.gate | pin_sync[1]) &
                (m1.mode != dtim_pkg::DTIM_SPLIT);
        en0h  = split & ctrl[`DTIM_B_TR1] &
                (clk_sel[1] ? tick4 : tick12);
        st0   = dtim_step(m0.mode, tl0, th0);
        st1   = dtim_step(m1.mode, tl1, th1);
        ovf0  = en0 & st0.ovf;
        ovf0h = en0h & (th0 == 8'hff);
        ovf1  = en1 & st1.ovf;
        tf1_set = split ? ovf0h : ovf1;

        // Counter bytes, software write last
        next_tl0 = en0 ? st0.tl : tl0;
        next_th0 = en0 ? st0.th : th0;
        if (en0h)
            next_th0 = th0 + 8'h01;
        next_tl1 = en1 ? st1.tl : tl1;
        next_th1 = en1 ? st1.th : th1;
        if (wr && paddr[11:2] == `DTIM_IDX_TL0)
            next_tl0 = pwdata[7:0];
        if (wr && paddr[11:2] == `DTIM_IDX_TH0)
            next_th0 = pwdata[7:0];
        if (wr && paddr[11:2] == `DTIM_IDX_TL1)
            next_tl1 = pwdata[7:0];
        if (wr && paddr[11:2] == `DTIM_IDX_TH1)
            next_th1 = pwdata[7:0];

        // Control bits: run and type from software
        next_ctrl = wr_ctrl ? pwdata[7:0] : ctrl;
        // Overflow flags: set beats vector clear beats write
        if (ovf0)
            next_ctrl[`DTIM_B_TF0] = 1'b1;
        else if (vec_t0)
            next_ctrl[`DTIM_B_TF0] = 1'b0;
        if (tf1_set)
            next_ctrl[`DTIM_B_TF1] = 1'b1;
        else if (vec_t1)
            next_ctrl[`DTIM_B_TF1] = 1'b0;
        // External detect flags
        if (!ctrl[`DTIM_B_IT0])
            next_ctrl[`DTIM_B_IE0] = ~pin_sync[0];
        else if (irq_fall[0])
            next_ctrl[`DTIM_B_IE0] = 1'b1;
        else if (vec_x0)
            next_ctrl[`DTIM_B_IE0] = 1'b0;
        if (!ctrl[`DTIM_B_IT1])
            next_ctrl[`DTIM_B_IE1] = ~pin_sync[1];
        else if (irq_fall[1])
            next_ctrl[`DTIM_B_IE1] = 1'b1;
        else if (vec_x1)
            next_ctrl[`DTIM_B_IE1] = 1'b0;

        next_mode_cfg = mode_cfg;
        if (wr && paddr[11:2] == `DTIM_IDX_MODE)
            next_mode_cfg = pwdata[7:0];
        next_clk_sel = clk_sel;
        if (wr && paddr[11:2] == `DTIM_IDX_CLK)
            next_clk_sel = {pwdata[`DTIM_B_CK1], pwdata[`DTIM_B_CK0]};
    end

    // Timer and control registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl     <= `DTIM_RST_BYTE;
            mode_cfg <= `DTIM_RST_BYTE;
            tl0      <= `DTIM_RST_BYTE;
            th0      <= `DTIM_RST_BYTE;
            tl1      <= `DTIM_RST_BYTE;
            th1      <= `DTIM_RST_BYTE;
            clk_sel  <= 2'h0;
        end else if (ce) begin
            ctrl     <= next_ctrl;
            mode_cfg <= next_mode_cfg;
            tl0      <= next_tl0;
            th0      <= next_th0;
            tl1      <= next_tl1;
            th1      <= next_th1;
            clk_sel  <= next_clk_sel;
        end
    end

    assign t0_overflow_flag     = ctrl[`DTIM_B_TF0];
    assign t1_overflow_flag     = ctrl[`DTIM_B_TF1];
    assign ext_irq0_detect_flag = ctrl[`DTIM_B_IE0];
    assign ext_irq1_detect_flag = ctrl[`DTIM_B_IE1];

    // ------------------------------------------------------------
    // Interrupt status and APB read path
    // ------------------------------------------------------------
    // Sticky status (set beats clear), mask, read capture
    always_comb begin
        next_istat = istat;
        if (wr && paddr[11:2] == `DTIM_IDX_ISTAT)
            next_istat = istat & ~pwdata[3:0];
        next_istat = next_istat |
            {next_ctrl[`DTIM_B_IE1] & ~ctrl[`DTIM_B_IE1],
             next_ctrl[`DTIM_B_IE0] & ~ctrl[`DTIM_B_IE0],
             tf1_set, ovf0};
        next_imask = imask;
        if (wr && paddr[11:2] == `DTIM_IDX_IMASK)
            next_imask = pwdata[3:0];
        next_data_ok = data_ok;
        next_prdata  = prdata;
        if (psel && !pwrite && !data_ok) begin
            next_data_ok = 1'b1;
            unique case (paddr[11:2])
                `DTIM_IDX_CTRL:  next_prdata = {24'h0, ctrl};
                `DTIM_IDX_MODE:  next_prdata = {24'h0, mode_cfg};
                `DTIM_IDX_TL0:   next_prdata = {24'h0, tl0};
                `DTIM_IDX_TL1:   next_prdata = {24'h0, tl1};
                `DTIM_IDX_TH0:   next_prdata = {24'h0, th0};
                `DTIM_IDX_TH1:   next_prdata = {24'h0, th1};
                `DTIM_IDX_CLK:   next_prdata = {27'h0, clk_sel, 3'h0};
                `DTIM_IDX_ISTAT: next_prdata = {28'h0, istat};
                `DTIM_IDX_IMASK: next_prdata = {28'h0, imask};
                default:         next_prdata = 32'h0;
            endcase
        end else if (pready) begin
            next_data_ok = 1'b0;
        end
    end

    // Status, mask and read data registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            istat   <= 4'h0;
            imask   <= 4'h0;
            data_ok <= 1'b0;
            prdata  <= 32'h0;
        end else if (ce) begin
            istat   <= next_istat;
            imask   <= next_imask;
            data_ok <= next_data_ok;
            prdata  <= next_prdata;
        end
    end

    assign pready  = ce & psel & penable & (pwrite | data_ok);
    assign pslverr = pready & ~dtim_hit(paddr);
    assign irq     = |(istat & imask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking dtim_cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_t0_wrap;
        ce && m0.mode == dtim_pkg::DTIM_RELOAD && ovf0 && !wr;
    endsequence

    chk_tf0_set_ovf: assert property (ce && ovf0 |=> t0_overflow_flag)
        else $error("timer 0 overflow did not set its flag");
    chk_tf1_set_ovf: assert property (ce && tf1_set |=> ctrl[7])
        else $error("timer 1 overflow did not set its flag");
    chk_tf_vector_clr: assert property (ce && vec_t0 && !ovf0 && !wr_ctrl
        |=> !t0_overflow_flag)
        else $error("vector did not clear timer 0 flag");
    chk_tf_sw_write: assert property (ce && wr_ctrl && !tf1_set && !vec_t1
        |=> ctrl[7] == $past(pwdata[7]))
        else $error("software write to timer 1 flag lost");
    chk_run_off_hold: assert property (ce && !ctrl[4] && !wr
        |=> tl0 == $past(tl0))
        else $error("timer 0 low byte moved while stopped");
    chk_level_follow: assert property (ce && !ctrl[0] && !ctrl[1]
        && !pin_sync[0] |=> ext_irq0_detect_flag)
        else $error("level detect flag not following pin");
    chk_edge_vec_clr: assert property (ce && ctrl[0] && vec_x0
        && !irq_fall[0] && !wr_ctrl |=> !ext_irq0_detect_flag)
        else $error("edge detect flag not cleared on vector");
    chk_edge_set: assert property (ce && ctrl[2] && irq_fall[1]
        |=> ext_irq1_detect_flag [*1] ##1 1)
        else $error("falling edge did not set detect flag");
    chk_gate_block: assert property (ce && m0.gate && !pin_sync[0] && !wr
        && !split |=> tl0 == $past(tl0) && th0 == $past(th0))
        else $error("gated timer 0 advanced with pin low");
    chk_t1_mode3_stop: assert property (ce && m1.mode == dtim_pkg::DTIM_SPLIT
        && !wr |=> $stable(tl1) && $stable(th1))
        else $error("timer 1 counted in mode 3");
    chk_reload_wrap: assert property (s_t0_wrap
        |=> tl0 == $past(th0) && t0_overflow_flag)
        else $error("auto-reload wrap did not reload");
    chk_div12_tick: assert property (ce && tick12 |=> !tick12 [*8])
        else $error("machine-cycle tick too frequent");

endmodule : dtim_top

// [sim/dtim_pins.sv]
// Pin-side partner: drives the interrupt and count pins of the timer block.
// Assumes one bench process calls its tasks at a time; pins idle high.
`timescale 1ns/1ps
module dtim_pins (
    // Clock
    input  wire logic core_clk,
    // Pins
    output logic      ext_irq0_pin,
    output logic      ext_irq1_pin,
    output logic      count_pin_0,
    output logic      count_pin_1
);
    logic [1:0] irq_lvl;
    logic [1:0] cnt_lvl;

    // Both pin pairs start released at their idle high level
    initial begin
        irq_lvl = 2'h3;
        cnt_lvl = 2'h3;
    end
    assign ext_irq0_pin = irq_lvl[0];
    assign ext_irq1_pin = irq_lvl[1];
    assign count_pin_0  = cnt_lvl[0];
    assign count_pin_1  = cnt_lvl[1];

    // Set one interrupt pin level just after an edge
    task automatic level(input int i, input logic v);
        @(posedge core_clk);
        irq_lvl[i] <= v;
    endtask : level

    // Falling edges on a count pin, each half two machine cycles long
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge core_clk);
            cnt_lvl[i] <= 1'b0;
            repeat (24) @(posedge core_clk);
            cnt_lvl[i] <= 1'b1;
            repeat (24) @(posedge core_clk);
        end
    endtask : pulse
endmodule : dtim_pins

// [sim/testbench.sv]
// Self-checking bench for the dual timer and external interrupt block.
// Assumes the pin partner in dtim_pins and the register index macros.
`timescale 1ns/1ps
`include "dtim_defs.svh"
module testbench;
    logic        core_clk;
    logic        rst_b;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        perr;
    logic [3:0]  vec;
    wire  [4:0]  flg;
    wire         x0;
    wire         x1;
    wire         c0;
    wire         c1;
    int          err_total;
    int          checks;
    int          cyc;
    logic [31:0] seed;

    // Design and pin partner
    dtim_top dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq0_pin(x0), .ext_irq1_pin(x1), .count_pin_0(c0),
        .count_pin_1(c1), .vec_t0(vec[0]), .vec_t1(vec[1]),
        .vec_x0(vec[2]), .vec_x1(vec[3]), .t0_overflow_flag(flg[0]),
        .t1_overflow_flag(flg[1]), .ext_irq0_detect_flag(flg[2]),
        .ext_irq1_detect_flag(flg[3]), .irq(flg[4]));
    dtim_pins pins_u (.core_clk(core_clk), .ext_irq0_pin(x0),
        .ext_irq1_pin(x1), .count_pin_0(c0), .count_pin_1(c1));

    // Clock and cycle count
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [7:0] d, output logic [31:0] r);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, idx, d, r);
    endtask : wr

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, idx, 8'h00, r);
        chk(r, exp);
    endtask : rdc

    // Poll a flag at falling edges for a bounded number of cycles
    task automatic wait_flg(input int k, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (flg[k] !== v && n < lim);
        chk({31'h0, flg[k]}, {31'h0, v});
    endtask : wait_flg

    task automatic vpulse(input int k);
        @(posedge core_clk);
        vec[k] <= 1'b1;
        @(posedge core_clk);
        vec[k] <= 1'b0;
    endtask : vpulse

    // Cycles between two overflow flag sets
    task automatic period(input int k, output int p);
        int t;
        wait_flg(k, 1'b1, 200);
        t = cyc;
        vpulse(k);
        wait_flg(k, 1'b1, 200);
        p = cyc - t;
        vpulse(k);
    endtask : period

    task automatic end_sim();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Watchdog
    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        end_sim();
    end

    // Main sequence
    initial begin
        int          i;
        int          p;
        int          n;
        int          d;
        logic [31:0] r;
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, vec} = '0;
        ce = 1'b1;
        seed = 32'h000096dd;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        // Reset values, unmapped index, control and mode access
        rdc(`DTIM_IDX_CTRL, 32'h00000000);
        rdc(10'h3ff, 32'h00000000);
        chk({31'h0, perr}, 32'h00000001);
        d = int'(rnd() & 32'hff);
        wr(`DTIM_IDX_MODE, 8'(d));
        rdc(`DTIM_IDX_MODE, 32'(d));
        wr(`DTIM_IDX_MODE, 8'h00);
        wr(`DTIM_IDX_CTRL, 8'h50);
        rdc(`DTIM_IDX_CTRL, 32'h00000050);
        wr(`DTIM_IDX_CTRL, 8'ha0);
        wait_flg(0, 1'b1, 1);
        wait_flg(1, 1'b1, 1);
        wr(`DTIM_IDX_CTRL, 8'h00);
        rdc(`DTIM_IDX_CTRL, 32'h00000000);
        wr(`DTIM_IDX_ISTAT, 8'h0f);
        // 16-bit wrap, status, mask and vector clear
        wr(`DTIM_IDX_MODE, 8'h01);
        wr(`DTIM_IDX_TL0, 8'hff);
        wr(`DTIM_IDX_TH0, 8'hff);
        wr(`DTIM_IDX_CTRL, 8'h10);
        wait_flg(0, 1'b1, 40);
        wr(`DTIM_IDX_CTRL, 8'h20);
        rdc(`DTIM_IDX_TH0, 32'h00000000);
        rdc(`DTIM_IDX_ISTAT, 32'h00000001);
        wr(`DTIM_IDX_IMASK, 8'h01);
        wait_flg(4, 1'b1, 2);
        wr(`DTIM_IDX_IMASK, 8'h00);
        wait_flg(4, 1'b0, 2);
        wr(`DTIM_IDX_IMASK, 8'h01);
        wr(`DTIM_IDX_ISTAT, 8'h01);
        wait_flg(4, 1'b0, 2);
        vpulse(0);
        wait_flg(0, 1'b0, 4);
        // Auto-reload period at both internal clock rates
        wr(`DTIM_IDX_MODE, 8'h20);
        wr(`DTIM_IDX_TH1, 8'hfc);
        wr(`DTIM_IDX_TL1, 8'hfc);
        for (i = 0; i < 2; i++) begin
            wr(`DTIM_IDX_CLK, (i == 0) ? 8'h10 : 8'h00);
            wr(`DTIM_IDX_CTRL, 8'h40);
            period(1, p);
            period(1, p);
            chk(32'(p), (i == 0) ? 32'h00000010 : 32'h00000030);
        end
        // Gating by the interrupt pin, then gating off
        wr(`DTIM_IDX_CTRL, 8'h00);
        wr(`DTIM_IDX_MODE, 8'h09);
        wr(`DTIM_IDX_TL0, 8'h00);
        wr(`DTIM_IDX_TH0, 8'h00);
        pins_u.level(0, 1'b0);
        wr(`DTIM_IDX_CTRL, 8'h10);
        repeat (100) @(posedge core_clk);
        rdc(`DTIM_IDX_TL0, 32'h00000000);
        wait_flg(2, 1'b1, 1);
        wr(`DTIM_IDX_MODE, 8'h01);
        repeat (60) @(posedge core_clk);
        apb(1'b0, `DTIM_IDX_TL0, 8'h00, r);
        chk({31'h0, r != 32'h0}, 32'h00000001);
        pins_u.level(0, 1'b1);
        wait_flg(2, 1'b0, 8);
        // Timer 1 mode 3 holds still
        wr(`DTIM_IDX_MODE, 8'h30);
        wr(`DTIM_IDX_TL1, 8'h00);
        wr(`DTIM_IDX_CTRL, 8'h40);
        repeat (100) @(posedge core_clk);
        rdc(`DTIM_IDX_TL1, 32'h00000000);
        // Event counting: 13-bit carry, then a random burst
        wr(`DTIM_IDX_MODE, 8'h04);
        wr(`DTIM_IDX_TL0, 8'hff);
        wr(`DTIM_IDX_TH0, 8'h12);
        wr(`DTIM_IDX_CTRL, 8'h10);
        pins_u.pulse(0, 1);
        rdc(`DTIM_IDX_TL0, 32'h000000e0);
        rdc(`DTIM_IDX_TH0, 32'h00000013);
        wr(`DTIM_IDX_MODE, 8'h05);
        n = int'(rnd() % 8) + 1;
        d = int'(rnd() & 32'hf0);
        wr(`DTIM_IDX_TL0, 8'(d));
        pins_u.pulse(0, n);
        rdc(`DTIM_IDX_TL0, 32'(d + n));
        // Edge and level detection on both interrupt inputs
        for (i = 0; i < 2; i++) begin
            wr(`DTIM_IDX_CTRL, 8'h01 << (2 * i));
            pins_u.level(i, 1'b0);
            wait_flg(2 + i, 1'b1, 40);
            vpulse(2 + i);
            wait_flg(2 + i, 1'b0, 4);
            wr(`DTIM_IDX_CTRL, 8'h00);
            wait_flg(2 + i, 1'b1, 8);
            vpulse(2 + i);
            wait_flg(2 + i, 1'b1, 1);
            pins_u.level(i, 1'b1);
            wait_flg(2 + i, 1'b0, 8);
        end
        // Timer 0 split: high byte on timer 1 run bit, frozen by enable
        wr(`DTIM_IDX_MODE, 8'h03);
        wr(`DTIM_IDX_TL0, 8'h00);
        wr(`DTIM_IDX_TH0, 8'hfe);
        wr(`DTIM_IDX_CTRL, 8'h40);
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (60) @(posedge core_clk);
        wait_flg(1, 1'b0, 1); // No wrap while the clock enable is low
        @(posedge core_clk);
        ce <= 1'b1;
        wait_flg(1, 1'b1, 40);
        rdc(`DTIM_IDX_TL0, 32'h00000000);
        end_sim();
    end
endmodule : testbench
